// ==== core/bkls_pkg.sv ====
// Package for the low-selection buck control register slice
package bkls_pkg;
    // --------------------------------------------------
    // Register offsets
    // --------------------------------------------------
    localparam logic [7:0] ADDR_LOW_SEL = 8'h11;
    localparam logic [7:0] ADDR_MODE = 8'h14;
    localparam logic [7:0] ADDR_PEAK = 8'h16;
    // --------------------------------------------------
    // Reset values and field positions
    // --------------------------------------------------
    localparam logic [7:0] RST_LOW_SEL = 8'hBF;
    localparam logic [1:0] RST_MODE = 2'h0;
    localparam logic [1:0] RST_PEAK = 2'h3;
    localparam int ENABLE_BIT = 7;
    localparam int LOW_PWM_BIT = 7;
    localparam int HIGH_PWM_BIT = 6;
    localparam logic [6:0] CODE_MIN = 7'h0F;
    localparam logic [7:0] RSVD_READ = 8'h00;
    // Register access request
    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [7:0] addr;
        logic [7:0] wdata;
    } bkls_req_s;
    // Settings handed to the analog core
    typedef struct packed {
        logic convEnable;
        logic [6:0] voltageCode;
        logic [1:0] bankCode;
        logic forcedPwm;
        logic [1:0] peakLimitCode;
    } bkls_core_s;
endpackage : bkls_pkg

// ==== core/bkls_regs.sv ====
// Low-selection enable, voltage, mode and peak-limit register slice
`timescale 1ns/1ps
module bkls_regs
    import bkls_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire bkls_req_s req,
    input wire logic enablePin,
    input wire logic voltageSelectPin,
    input wire logic highSelectEnableGate,
    input wire logic [6:0] highSelectVoltageCode,
    input wire logic [1:0] lowBankCode,
    input wire logic [1:0] highBankCode,
    output logic [7:0] rdata,
    output logic rdValid,
    output bkls_core_s coreCfg
);
    // --------------------------------------------------
    // Register state
    // --------------------------------------------------
    logic [7:0] lowSel_r, lowSel_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [1:0] peak_r, peak_nxt;
    logic [7:0] rdata_r, rdata_nxt;
    logic rdValid_r, rdValid_nxt;
    bkls_core_s core_r, core_nxt;

    // --------------------------------------------------
    // Address decode and read path
    // --------------------------------------------------
    // True for the low-selection enable and voltage offset
    function automatic logic isLowSel(input logic [7:0] a);
        return a == ADDR_LOW_SEL;
    endfunction : isLowSel

    // True for the operating mode offset
    function automatic logic isMode(input logic [7:0] a);
        return a == ADDR_MODE;
    endfunction : isMode

    // True for the peak-limit offset
    function automatic logic isPeak(input logic [7:0] a);
        return a == ADDR_PEAK;
    endfunction : isPeak

    // True for any offset this slice answers
    function automatic logic isMapped(input logic [7:0] a);
        return isLowSel(a) || isMode(a) || isPeak(a);
    endfunction : isMapped

    // Read mux, reserved positions constant
    function automatic logic [7:0] readMux(input logic [7:0] a, input logic [7:0] ls,
                                           input logic [1:0] md, input logic [1:0] pk);
        case (a)
            ADDR_LOW_SEL: readMux = ls;
            ADDR_MODE: readMux = {md, RSVD_READ[5:0]};
            ADDR_PEAK: readMux = {pk, RSVD_READ[5:0]};
            default: readMux = RSVD_READ;
        endcase
    endfunction : readMux

    // --------------------------------------------------
    // Next-state logic
    // --------------------------------------------------
    // Next-state for registers and outputs
    always_comb begin
        lowSel_nxt = lowSel_r;
        mode_nxt = mode_r;
        peak_nxt = peak_r;
        // Writes never depend on enable pin
        if (req.wrEn) begin
            case (req.addr)
                ADDR_LOW_SEL: lowSel_nxt = req.wdata;
                ADDR_MODE: mode_nxt = req.wdata[7:6];
                ADDR_PEAK: peak_nxt = req.wdata[7:6];
                default: lowSel_nxt = lowSel_r;
            endcase
        end
        rdValid_nxt = req.rdEn;
        rdata_nxt = req.rdEn ? readMux(req.addr, lowSel_r, mode_r, peak_r) : rdata_r;
        // Core settings except peak limit follow select pin
        if (!voltageSelectPin) begin
            core_nxt.convEnable = enablePin & lowSel_r[ENABLE_BIT];
            core_nxt.voltageCode = lowSel_r[6:0];
            core_nxt.bankCode = lowBankCode;
            core_nxt.forcedPwm = mode_r[LOW_PWM_BIT - 6];
        end else begin
            core_nxt.convEnable = enablePin & highSelectEnableGate;
            core_nxt.voltageCode = highSelectVoltageCode;
            core_nxt.bankCode = highBankCode;
            core_nxt.forcedPwm = mode_r[HIGH_PWM_BIT - 6];
        end
        core_nxt.peakLimitCode = peak_r;
    end

    // --------------------------------------------------
    // State registers
    // --------------------------------------------------
    // Register update
    always_ff @(posedge clk) begin
        if (srst) begin
            lowSel_r <= RST_LOW_SEL;
            mode_r <= RST_MODE;
            peak_r <= RST_PEAK;
            rdata_r <= 8'h00;
            rdValid_r <= 1'b0;
            core_r <= '0;
        end else begin
            lowSel_r <= lowSel_nxt;
            mode_r <= mode_nxt;
            peak_r <= peak_nxt;
            rdata_r <= rdata_nxt;
            rdValid_r <= rdValid_nxt;
            core_r <= core_nxt;
        end
    end

    // --------------------------------------------------
    // Outputs
    // --------------------------------------------------
    // Every output straight from its flop
    assign rdata = rdata_r;
    assign rdValid = rdValid_r;
    assign coreCfg = core_r;

    // --------------------------------------------------
    // Assertions
    // --------------------------------------------------
    a_low_enable_gate: assert property (@(posedge clk) disable iff (srst)
        !voltageSelectPin |=> coreCfg.convEnable == ($past(enablePin) & $past(lowSel_r[7])))
        else $error("low enable gate wrong");
    a_high_enable_gate: assert property (@(posedge clk) disable iff (srst)
        voltageSelectPin |=> coreCfg.convEnable == ($past(enablePin) & $past(highSelectEnableGate)))
        else $error("high enable gate wrong");
    a_low_code_out: assert property (@(posedge clk) disable iff (srst)
        (req.wrEn && req.addr == ADDR_LOW_SEL && !voltageSelectPin) ##1 !voltageSelectPin
        |=> coreCfg.voltageCode == $past(req.wdata[6:0], 2))
        else $error("low code not applied");
    a_low_bank_out: assert property (@(posedge clk) disable iff (srst)
        !voltageSelectPin |=> coreCfg.bankCode == $past(lowBankCode))
        else $error("low bank not applied");
    a_low_mode_sel: assert property (@(posedge clk) disable iff (srst)
        !voltageSelectPin |=> coreCfg.forcedPwm == $past(mode_r[1]))
        else $error("low mode bit wrong");
    a_high_mode_sel: assert property (@(posedge clk) disable iff (srst)
        voltageSelectPin |=> coreCfg.forcedPwm == $past(mode_r[0]))
        else $error("high mode bit wrong");
    a_mode_reset: assert property (@(posedge clk)
        srst |=> mode_r == 2'h0)
        else $error("mode not reset to auto");
    a_peak_reset: assert property (@(posedge clk)
        srst ##1 !srst |=> coreCfg.peakLimitCode == 2'h3)
        else $error("peak code reset wrong");
    a_rsvd_read: assert property (@(posedge clk) disable iff (srst)
        (req.rdEn && (req.addr == ADDR_MODE || req.addr == ADDR_PEAK)) |=> rdata[5:0] == 6'h00)
        else $error("reserved bits not zero");
    a_write_when_off: assert property (@(posedge clk) disable iff (srst)
        (req.wrEn && req.addr == ADDR_PEAK && !enablePin) |=> peak_r == $past(req.wdata[7:6]))
        else $error("write lost while off");

    // --------------------------------------------------
    // Read path, write, retention, output and reset assertions and covers
    // --------------------------------------------------
    a_read_valid_pulse: assert property (@(posedge clk) disable iff (srst)
        req.rdEn |=> rdValid)
        else $error("read valid missing");
    a_no_read_valid: assert property (@(posedge clk) disable iff (srst)
        !req.rdEn |=> !rdValid)
        else $error("read valid without read");
    a_low_sel_read: assert property (@(posedge clk) disable iff (srst)
        (req.rdEn && isLowSel(req.addr)) |=> rdata == $past(lowSel_r))
        else $error("low select read wrong");
    a_unmapped_read: assert property (@(posedge clk) disable iff (srst)
        (req.rdEn && !isMapped(req.addr)) |=> rdata == RSVD_READ)
        else $error("unmapped read not constant");
    a_rdata_hold: assert property (@(posedge clk) disable iff (srst)
        !req.rdEn |=> $stable(rdata))
        else $error("read data moved without read");
    a_low_sel_write: assert property (@(posedge clk) disable iff (srst)
        (req.wrEn && isLowSel(req.addr)) |=> lowSel_r == $past(req.wdata))
        else $error("low select write lost");
    a_low_sel_retain: assert property (@(posedge clk) disable iff (srst)
        !(req.wrEn && isLowSel(req.addr)) |=> lowSel_r == $past(lowSel_r))
        else $error("low select not retained");
    a_mode_write: assert property (@(posedge clk) disable iff (srst)
        (req.wrEn && isMode(req.addr)) |=> mode_r == $past(req.wdata[7:6]))
        else $error("mode write lost");
    a_mode_retain: assert property (@(posedge clk) disable iff (srst)
        !(req.wrEn && isMode(req.addr)) |=> mode_r == $past(mode_r))
        else $error("mode not retained");
    a_peak_retain: assert property (@(posedge clk) disable iff (srst)
        !(req.wrEn && isPeak(req.addr)) |=> peak_r == $past(peak_r))
        else $error("peak code not retained");
    a_peak_code_out: assert property (@(posedge clk) disable iff (srst)
        (req.wrEn && isPeak(req.addr)) |=> ##1 coreCfg.peakLimitCode == $past(req.wdata[7:6], 2))
        else $error("peak code not applied");
    a_high_bank_out: assert property (@(posedge clk) disable iff (srst)
        voltageSelectPin |=> coreCfg.bankCode == $past(highBankCode))
        else $error("high bank not applied");
    a_reset_outputs: assert property (@(posedge clk)
        srst |=> !rdValid && coreCfg == '0)
        else $error("outputs not cleared by reset");
    a_low_sel_reset: assert property (@(posedge clk)
        srst |=> lowSel_r == 8'hBF)
        else $error("low select reset value wrong");
    c_low_enabled: cover property (@(posedge clk) !voltageSelectPin ##1 coreCfg.convEnable);
    c_high_pwm: cover property (@(posedge clk) voltageSelectPin ##1 coreCfg.forcedPwm);
    c_peak_write: cover property (@(posedge clk) req.wrEn && req.addr == ADDR_PEAK);
    c_read_back: cover property (@(posedge clk) rdValid && rdata == RST_LOW_SEL);
    c_unmapped_read: cover property (@(posedge clk) req.rdEn && !isMapped(req.addr));
endmodule : bkls_regs

// ==== tb/bkls_host_model.sv ====
// Register host model driving the read and write strobes
`timescale 1ns/1ps
module bkls_host_model
    import bkls_pkg::*;
(
    input wire logic clk,
    output bkls_req_s req,
    input wire logic [7:0] rdata,
    input wire logic rdValid
);
    initial req = '{1'b0, 1'b0, 8'h00, 8'h00};
    // One-cycle write strobe, then scrambled idle address and data
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req <= '{1'b1, 1'b0, a, d};
        @(negedge clk);
        req <= '{1'b0, 1'b0, ~a, ~d};
    endtask : wr
    // Read strobe; data and valid taken one cycle later
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge clk);
        d = rdata;
        v = rdValid;
        req <= '{1'b0, 1'b0, ~a, 8'hFF};
    endtask : rd
endmodule : bkls_host_model

// ==== tb/bkls_tb_top.sv ====
// Self-checking bench for the low-selection register slice
`timescale 1ns/1ps
`define CHK(n, e, a) begin comparisons++; if ((e) !== (a)) begin badCount++; \
    $display("CHECK FAILED %s exp %0h got %0h", n, e, a); end end
module buck_low_select_control_regs_tb_top;
    import bkls_pkg::*;
    localparam logic [7:0] ADR [4] = '{ADDR_LOW_SEL, ADDR_MODE, ADDR_PEAK, 8'h12};
    logic clk = 1'b0, srst = 1'b1, en = 1'b0, vs = 1'b0, hg = 1'b0, rdValid, v;
    logic [6:0] hc = 7'h00;
    logic [1:0] lb = 2'h0, hb = 2'h0;
    logic [7:0] rdata, d;
    logic [7:0] sh [3];
    logic [31:0] seed = 32'h72A2;
    bkls_req_s req;
    bkls_core_s cfg;
    int badCount = 0, comparisons = 0, i, k;
    bkls_regs dut (.clk(clk), .srst(srst), .req(req), .enablePin(en), .voltageSelectPin(vs),
        .highSelectEnableGate(hg), .highSelectVoltageCode(hc), .lowBankCode(lb),
        .highBankCode(hb), .rdata(rdata), .rdValid(rdValid), .coreCfg(cfg));
    bkls_host_model host (.clk(clk), .req(req), .rdata(rdata), .rdValid(rdValid));
    initial forever #20 clk = ~clk;
    // Xorshift step for repeatable stimulus
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction : xs
    // Settings the core should see, from shadow registers and pins
    function automatic bkls_core_s expCfg();
        if (vs) return bkls_core_s'{en & hg, hc, hb, sh[1][6], sh[2][7:6]};
        return bkls_core_s'{en & sh[0][7], sh[0][6:0], lb, sh[1][7], sh[2][7:6]};
    endfunction : expCfg
    // Prints counts and verdict, ends the run
    task automatic tallyAndFinish();
        $display("comparisons %0d mismatches %0d", comparisons, badCount);
        if (badCount == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : tallyAndFinish
    // Watchdog against a hung handshake
    initial begin
        #(40 * 2000);
        badCount++;
        tallyAndFinish();
    end
    // Reset values, then random writes with pin changes and read-back
    initial begin
        sh = '{8'hBF, 8'h00, 8'hC0};
        repeat (20) @(negedge clk);
        srst = 1'b0;
        for (k = 0; k < 4; k++) begin
            host.rd(ADR[k], d, v);
            `CHK("reset read", (k < 3) ? sh[k] : RSVD_READ, d)
            `CHK("read valid", 1'b1, v)
        end
        for (i = 0; i < 60; i++) begin
            seed = xs(seed);
            k = seed[1:0];
            d = seed[15:8];
            if (k == 0 && d[6:0] < CODE_MIN) d[6:0] = CODE_MIN;
            {en, vs, hg, hc, lb, hb} = seed[30:17];
            host.wr(ADR[k], d);
            if (k < 3) sh[k] = d & ((k != 0) ? 8'hC0 : 8'hFF);
            @(negedge clk);
            `CHK("core settings", expCfg(), cfg)
            host.rd(ADR[k], d, v);
            `CHK("read back", (k < 3) ? sh[k] : RSVD_READ, d)
            `CHK("read back valid", 1'b1, v)
        end
        tallyAndFinish();
    end
endmodule : buck_low_select_control_regs_tb_top
